// File: shared/tcp_pkg.sv
`default_nettype none
package tcp_pkg;
  // Register byte offsets
  localparam logic [7:0] TCP_CTRL_OFS = 8'h00;
  localparam logic [7:0] TCP_TOP_OFS = 8'h04;
  localparam logic [7:0] TCP_CMP_OFS = 8'h08;
  localparam logic [7:0] TCP_CNT_OFS = 8'h0c;
  localparam logic [7:0] TCP_CAP_OFS = 8'h10;
  localparam logic [7:0] TCP_STAT_OFS = 8'h14;
  localparam logic [7:0] TCP_MASK_OFS = 8'h18;
  localparam logic [7:0] TCP_STATE_OFS = 8'h1c;
  // Control field positions
  localparam int TCP_C_MODE_LO = 0;
  localparam int TCP_C_SRC = 2;
  localparam int TCP_C_PRE_LO = 3;
  localparam int TCP_C_DOWN = 6;
  localparam int TCP_C_EN = 7;
  localparam int TCP_C_CAPEN = 8;
  localparam int TCP_C_INV = 9;
  localparam int TCP_C_WAKE = 10;
  localparam int TCP_C_RSTEN = 11;
  localparam int TCP_CTRL_W = 12;
  // Status and mask bit positions
  localparam int TCP_S_OVF = 0;
  localparam int TCP_S_MATCH = 1;
  localparam int TCP_S_CAP = 2;
  localparam int TCP_STAT_W = 3;
  // Reset values
  localparam logic [TCP_CTRL_W-1:0] TCP_CTRL_RST = 12'h880;
  localparam logic [15:0] TCP_TOP_RST = 16'hffff;
  localparam logic [15:0] TCP_CMP_RST = 16'h8000;
  localparam logic [TCP_STAT_W-1:0] TCP_MASK_RST = 3'h0;
  // Prescaler divide-minus-one values per select code
  localparam int TCP_PRE_W = 10;
  localparam logic [TCP_PRE_W-1:0] TCP_DIV1 = 10'h000;
  localparam logic [TCP_PRE_W-1:0] TCP_DIV8 = 10'h007;
  localparam logic [TCP_PRE_W-1:0] TCP_DIV64 = 10'h03f;
  localparam logic [TCP_PRE_W-1:0] TCP_DIV256 = 10'h0ff;
  localparam logic [TCP_PRE_W-1:0] TCP_DIV1024 = 10'h3ff;
  typedef enum logic [1:0] {
    TCP_MODE_WDT,
    TCP_MODE_CTC,
    TCP_MODE_FPWM,
    TCP_MODE_PFC
  } tcp_mode_e;
endpackage
`default_nettype wire

// File: src/tcp_timer.sv
// How it works
// - 16-bit counter counting up or down with its own compare unit.
// - Modes: watchdog, clear on compare match, fast PWM, phase-frequency PWM.
// - Count source selectable: bus clock or external count clock.
// - Programmable prescaler divides the selected count source.
// - One static interrupt output towards routing.
// - One wake-up interrupt output towards the standby controller.
// - Interrupt sources: overflow, compare match, input capture.
// - Glitch-free PWM output with a variable period.
// - Control and status registers answer bus reads and writes.
// - Without bus, run from preloaded settings and a direct reset pin.
// - Reset pin stays enabled; its enable bit is preset and fixed.
// - Enabled capture takes synchronised rising edges and copies the count.
// - Capture only in non-PWM modes and only with bus in use.
// - Without bus, the interrupt output shows the overflow flag.
// - With bus, interrupt follows the status and mask registers.
// - Waveform, compare or PWM output appears on the waveform pin.
// - Capture latches the count in the cycle the synchronised trigger edge is detected.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter logic [TCP_CTRL_W-1:0] PRE_CTRL = TCP_CTRL_RST,
  parameter logic [15:0] PRE_TOP = TCP_TOP_RST,
  parameter logic [15:0] PRE_CMP = TCP_CMP_RST
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bus_in_use,
  input wire logic count_clock_in,
  input wire logic timer_reset_n_pin,
  input wire logic capture_trigger_in,
  output logic timer_interrupt_out,
  output logic wake_interrupt_out,
  output logic waveform_out
);

  function automatic logic [TCP_PRE_W-1:0] div_of(input logic [2:0] sel);
    case (sel)
      3'h1: div_of = TCP_DIV8;
      3'h2: div_of = TCP_DIV64;
      3'h3: div_of = TCP_DIV256;
      3'h4: div_of = TCP_DIV1024;
      default: div_of = TCP_DIV1;
    endcase
  endfunction

  logic [TCP_CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0] top_r, cmp_r, top_act_r, cmp_act_r;
  logic [CNT_W-1:0] count_r, capture_r;
  logic [TCP_STAT_W-1:0] status_r, mask_r;
  logic up_r, wave_r;
  logic [TCP_PRE_W-1:0] pre_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  // Pin synchronisers, two flops each
  logic cclk_s1, cclk_s2, cclk_prev;
  logic rstp_s1, rstp_s2;
  logic cap_s1, cap_s2, cap_prev;
  logic bus_s1, bus_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cclk_s1 <= 1'b0;
      cclk_s2 <= 1'b0;
      cclk_prev <= 1'b0;
      // Pin idles high, so no false pin reset follows a bus reset
      rstp_s1 <= 1'b1;
      rstp_s2 <= 1'b1;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_prev <= 1'b0;
      bus_s1 <= 1'b0;
      bus_s2 <= 1'b0;
    end else begin
      cclk_s1 <= count_clock_in;
      cclk_s2 <= cclk_s1;
      cclk_prev <= cclk_s2;
      rstp_s1 <= timer_reset_n_pin;
      rstp_s2 <= rstp_s1;
      cap_s1 <= capture_trigger_in;
      cap_s2 <= cap_s1;
      cap_prev <= cap_s2;
      bus_s1 <= bus_in_use;
      bus_s2 <= bus_s1;
    end
  end

  tcp_mode_e mode;
  logic pwm, pin_rst, src_ev, tick, cap_take;
  logic at_top, at_bot, wrap_ev, match_ev, buf_load;
  logic [CNT_W-1:0] lim;
  logic addr_ok, wr_fire;
  logic [TCP_STAT_W-1:0] stat_set, stat_clr;

  assign mode = tcp_mode_e'(ctrl_r[TCP_C_MODE_LO +: 2]);
  assign pwm = (mode == TCP_MODE_FPWM) || (mode == TCP_MODE_PFC);
  // Reset pin enable is fixed at one, so the pin always acts
  assign pin_rst = ctrl_r[TCP_C_RSTEN] && !rstp_s2;
  assign src_ev = ctrl_r[TCP_C_SRC] ? (cclk_s2 && !cclk_prev) : 1'b1;
  assign tick = ctrl_r[TCP_C_EN] && src_ev &&
    (pre_r >= div_of(ctrl_r[TCP_C_PRE_LO +: 3]));
  assign lim = (mode == TCP_MODE_CTC) ? cmp_act_r : top_act_r;
  assign at_top = count_r >= lim;
  assign at_bot = count_r == '0;
  assign match_ev = tick && (count_r == cmp_act_r);
  always_comb begin
    wrap_ev = 1'b0;
    if (tick) begin
      unique case (mode)
        TCP_MODE_WDT, TCP_MODE_CTC: begin
          wrap_ev = ctrl_r[TCP_C_DOWN] ? at_bot : at_top;
        end
        TCP_MODE_FPWM: begin
          wrap_ev = at_top;
        end
        TCP_MODE_PFC: begin
          wrap_ev = !up_r && at_bot;
        end
      endcase
    end
  end
  assign buf_load = !pwm || wrap_ev;
  assign cap_take = cap_s2 && !cap_prev && ctrl_r[TCP_C_CAPEN] &&
    !pwm && bus_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
    end else if (pin_rst || tick) begin
      pre_r <= '0;
    end else if (ctrl_r[TCP_C_EN] && src_ev) begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Counter and direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
      up_r <= 1'b1;
    end else if (pin_rst) begin
      count_r <= '0;
      up_r <= 1'b1;
    end else if (wr_fire && wr_addr_r == TCP_CNT_OFS) begin
      count_r <= hwdata[CNT_W-1:0];
    end else if (tick) begin
      unique case (mode)
        TCP_MODE_WDT, TCP_MODE_CTC: begin
          if (ctrl_r[TCP_C_DOWN]) begin
            count_r <= at_bot ? lim : count_r - 1'b1;
          end else begin
            count_r <= at_top ? '0 : count_r + 1'b1;
          end
        end
        TCP_MODE_FPWM: begin
          count_r <= at_top ? '0 : count_r + 1'b1;
        end
        TCP_MODE_PFC: begin
          if (up_r && at_top) begin
            up_r <= 1'b0;
            count_r <= at_bot ? count_r : count_r - 1'b1;
          end else if (up_r) begin
            count_r <= count_r + 1'b1;
          end else if (at_bot) begin
            up_r <= 1'b1;
            count_r <= (lim == '0) ? count_r : count_r + 1'b1;
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Period and compare buffers update only at the cycle boundary in PWM
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_act_r <= TCP_TOP_RST;
      cmp_act_r <= TCP_CMP_RST;
    end else if (buf_load) begin
      top_act_r <= top_r;
      cmp_act_r <= cmp_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_r <= 1'b0;
    end else if (pin_rst) begin
      wave_r <= ctrl_r[TCP_C_INV];
    end else if (pwm) begin
      wave_r <= (count_r < cmp_act_r) ^ ctrl_r[TCP_C_INV];
    end else if (match_ev) begin
      wave_r <= !wave_r;
    end
  end
  assign waveform_out = wave_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_r <= '0;
    end else if (cap_take) begin
      capture_r <= count_r;
    end
  end

  // Interrupt flags: set wins over a write-one clear
  assign stat_set = {cap_take, match_ev, wrap_ev};
  assign stat_clr = (wr_fire && wr_addr_r == TCP_STAT_OFS) ?
    hwdata[TCP_STAT_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~stat_clr) | stat_set;
    end
  end

  assign timer_interrupt_out = bus_s2 ? |(status_r & mask_r) :
    status_r[TCP_S_OVF];
  assign wake_interrupt_out = timer_interrupt_out &&
    ctrl_r[TCP_C_WAKE];

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_fire = wr_pend_r && bus_s2;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= '0;
      unique case (haddr)
        TCP_CTRL_OFS: hrdata_r[TCP_CTRL_W-1:0] <= ctrl_r;
        TCP_TOP_OFS: hrdata_r[CNT_W-1:0] <= top_r;
        TCP_CMP_OFS: hrdata_r[CNT_W-1:0] <= cmp_r;
        TCP_CNT_OFS: hrdata_r[CNT_W-1:0] <= count_r;
        TCP_CAP_OFS: hrdata_r[CNT_W-1:0] <= capture_r;
        TCP_STAT_OFS: hrdata_r[TCP_STAT_W-1:0] <= status_r;
        TCP_MASK_OFS: hrdata_r[TCP_STAT_W-1:0] <= mask_r;
        TCP_STATE_OFS: hrdata_r[1:0] <= {up_r, wave_r};
        default: hrdata_r <= '0;
      endcase
    end
  end

  // Control registers start from preloaded values; writes need the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= PRE_CTRL | (12'h001 << TCP_C_RSTEN);
      top_r <= PRE_TOP;
      cmp_r <= PRE_CMP;
      mask_r <= TCP_MASK_RST;
    end else if (wr_fire) begin
      unique case (wr_addr_r)
        TCP_CTRL_OFS: begin
          ctrl_r <= hwdata[TCP_CTRL_W-1:0] | (12'h001 << TCP_C_RSTEN);
        end
        TCP_TOP_OFS: top_r <= hwdata[CNT_W-1:0];
        TCP_CMP_OFS: cmp_r <= hwdata[CNT_W-1:0];
        TCP_MASK_OFS: mask_r <= hwdata[TCP_STAT_W-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_top_hit;
    tick && !pin_rst && mode == TCP_MODE_PFC && up_r && at_top && !wr_fire;
  endsequence
  sequence s_cap_edge;
    cap_take && !pin_rst;
  endsequence

  a_pfc_turn_down: assert property (s_top_hit |=> !up_r)
    else $error("phase correct PWM did not turn at top");
  a_capture_latch: assert property (s_cap_edge |=>
    capture_r == $past(count_r))
    else $error("capture register missed the count");
  a_capture_pwm_block: assert property (pwm |-> !cap_take)
    else $error("capture taken in a PWM mode");
  a_fpwm_reload: assert property (tick && !pin_rst && !wr_fire &&
    mode == TCP_MODE_FPWM && at_top |=> count_r == '0)
    else $error("fast PWM counter did not reload");
  a_ovf_sticky: assert property (status_r[TCP_S_OVF] &&
    !stat_clr[TCP_S_OVF] |=> status_r[TCP_S_OVF])
    else $error("overflow flag dropped without a clear");
  a_standalone_irq: assert property (!bus_s2 |->
    timer_interrupt_out == status_r[TCP_S_OVF])
    else $error("stand-alone interrupt not the overflow flag");
  a_irq_raise: assert property (bus_s2 && mask_r[TCP_S_MATCH] &&
    $rose(status_r[TCP_S_MATCH]) |-> timer_interrupt_out)
    else $error("unmasked match flag did not interrupt");
  a_pin_reset: assert property (pin_rst ##1 pin_rst |->
    count_r == '0 && pre_r == '0)
    else $error("reset pin did not clear the counter");
  a_pwm_wave: assert property (pwm && !pin_rst ##1 pwm |->
    waveform_out == ($past(count_r < cmp_act_r) ^
    $past(ctrl_r[TCP_C_INV])))
    else $error("PWM output does not follow the compare");
  a_bus_okay: assert property (wr_pend_r |-> hreadyout && !hresp)
    else $error("bus answer not ready and OKAY");

  // Reload, flag and output behaviour
  sequence s_bot_hit;
    tick && !pin_rst && !wr_fire && !pwm && ctrl_r[TCP_C_DOWN] && at_bot;
  endsequence

  a_up_wrap: assert property (tick && !pin_rst && !wr_fire && !pwm &&
    !ctrl_r[TCP_C_DOWN] && at_top |=> count_r == '0)
    else $error("up counter did not wrap to zero");

  a_down_reload: assert property (s_bot_hit |=> count_r == $past(lim))
    else $error("down counter did not reload from its limit");

  a_pre_clear: assert property (tick |=> pre_r == '0)
    else $error("prescaler did not restart after a tick");

  a_match_flag: assert property (match_ev |=> status_r[TCP_S_MATCH])
    else $error("match event did not set its flag");

  a_capture_flag: assert property (cap_take |=> status_r[TCP_S_CAP])
    else $error("capture event did not set its flag");

  a_match_toggle: assert property (match_ev && !pwm && !pin_rst |=>
    waveform_out != $past(waveform_out))
    else $error("compare match did not toggle the output");

  a_pwm_buffer: assert property (pwm && !wrap_ev |=>
    $stable(top_act_r) && $stable(cmp_act_r))
    else $error("PWM period or compare changed mid cycle");

  // Stand-alone mode and fixed reset pin enable
  a_standalone_wr: assert property (!bus_s2 && wr_pend_r |=>
    $stable(ctrl_r) && $stable(top_r) && $stable(cmp_r) && $stable(mask_r))
    else $error("register write taken in stand-alone mode");

  a_rsten_fixed: assert property (ctrl_r[TCP_C_RSTEN])
    else $error("reset pin enable was cleared");

endmodule
`default_nettype wire

// File: bench/tcp_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcp_pins_model (
  input wire logic hclk,
  output logic count_clock_in,
  output logic capture_trigger_in,
  output logic timer_reset_n_pin
);
  // Count source stands low between bursts
  initial begin
    count_clock_in = 1'b0;
    capture_trigger_in = 1'b0;
    timer_reset_n_pin = 1'b1;
  end
  // Three cycles high and three low, above the two-cycle minimum
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge hclk);
      count_clock_in <= 1'b1;
      repeat (3) @(posedge hclk);
      count_clock_in <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask
  task automatic trigger();
    @(posedge hclk);
    capture_trigger_in <= 1'b1;
    repeat (3) @(posedge hclk);
    capture_trigger_in <= 1'b0;
  endtask
  task automatic pin_reset();
    @(posedge hclk);
    timer_reset_n_pin <= 1'b0;
    repeat (5) @(posedge hclk);
    timer_reset_n_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: bench/timer_counter_pwm_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_capture_bench;
  import tcp_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } tcp_row_s;
  logic hclk, hresetn, hsel, hwrite, bus_in_use, hreadyout, hresp;
  logic irq, wake, wave, cnt_clk, pin_rst_n, trig;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  int num_errors, compares, ones;
  tcp_row_s rows[12] = '{
    '{TCP_CTRL_OFS, 1'b0, 32'h0, 32'h880},
    '{TCP_TOP_OFS, 1'b0, 32'h0, 32'hffff},
    '{TCP_CMP_OFS, 1'b0, 32'h0, 32'h8000},
    '{TCP_MASK_OFS, 1'b0, 32'h0, 32'h0},
    '{TCP_STATE_OFS, 1'b0, 32'h0, 32'h2},
    '{TCP_CAP_OFS, 1'b0, 32'h0, 32'h0},
    '{TCP_CTRL_OFS, 1'b1, 32'h0, 32'h0},
    '{TCP_CTRL_OFS, 1'b0, 32'h0, 32'h800},
    '{TCP_TOP_OFS, 1'b1, 32'h1234, 32'h0},
    '{TCP_TOP_OFS, 1'b0, 32'h0, 32'h1234},
    '{8'h20, 1'b1, 32'h55, 32'h0},
    '{8'h20, 1'b0, 32'h0, 32'h0}};
  tcp_timer u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bus_in_use(bus_in_use), .count_clock_in(cnt_clk),
    .timer_reset_n_pin(pin_rst_n), .capture_trigger_in(trig),
    .timer_interrupt_out(irq), .wake_interrupt_out(wake),
    .waveform_out(wave)
  );
  tcp_pins_model u_pins (
    .hclk(hclk), .count_clock_in(cnt_clk),
    .capture_trigger_in(trig), .timer_reset_n_pin(pin_rst_n)
  );
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic final_report();
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 8'h00;
    hwdata = 32'h0;
    bus_in_use = 1'b1;
    tick(10);
    hresetn <= 1'b1;
    tick(3);
    chk({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 12; i++) begin
      xfer(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk(rd, rows[i].e);
    end
    wr(TCP_TOP_OFS, 32'h3);
    wr(TCP_CMP_OFS, 32'h2);
    // Pass 4 is the watchdog counting down
    for (int m = 0; m < 5; m++) begin
      wr(TCP_STAT_OFS, 32'h7);
      wr(TCP_CNT_OFS, 32'h0);
      wr(TCP_CTRL_OFS, 32'h80 | ((m == 4) ? 32'h40 : 32'(m)));
      tick(4);
      ones = 0;
      repeat (24) begin
        @(negedge hclk);
        ones += wave;
      end
      wr(TCP_CTRL_OFS, 32'h0);
      xfer(TCP_STAT_OFS, 1'b0, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      chk({31'h0, rd[1]}, 32'h1);
      chk(32'(ones), 32'd12);
    end
    wr(TCP_MASK_OFS, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr(TCP_CTRL_OFS, 32'h400);
    tick(1);
    chk({31'h0, wake}, 32'h1);
    wr(TCP_MASK_OFS, 32'h0);
    tick(1);
    chk({30'h0, irq, wake}, 32'h0);
    wr(TCP_MASK_OFS, 32'h1);
    wr(TCP_STAT_OFS, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    wr(TCP_CNT_OFS, 32'habc);
    wr(TCP_CTRL_OFS, 32'h100);
    u_pins.trigger();
    tick(8);
    xfer(TCP_CAP_OFS, 1'b0, 32'h0);
    chk(rd, 32'habc);
    xfer(TCP_STAT_OFS, 1'b0, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    wr(TCP_STAT_OFS, 32'h7);
    wr(TCP_CTRL_OFS, 32'h102);
    wr(TCP_CNT_OFS, 32'h123);
    u_pins.trigger();
    tick(8);
    xfer(TCP_CAP_OFS, 1'b0, 32'h0);
    chk(rd, 32'habc);
    xfer(TCP_STAT_OFS, 1'b0, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    wr(TCP_CTRL_OFS, 32'h0c);
    u_pins.pin_reset();
    tick(3);
    xfer(TCP_CNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wr(TCP_CTRL_OFS, 32'h8c);
    u_pins.edges(16);
    tick(6);
    xfer(TCP_CNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h2);
    wr(TCP_MASK_OFS, 32'h0);
    wr(TCP_CTRL_OFS, 32'h80);
    tick(4);
    chk({31'h0, irq}, 32'h0);
    bus_in_use <= 1'b0;
    tick(4);
    chk({31'h0, irq}, 32'h1);
    wr(TCP_TOP_OFS, 32'h42);
    xfer(TCP_TOP_OFS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    bus_in_use <= 1'b1;
    wr(TCP_CTRL_OFS, 32'h82);
    tick(5);
    hresetn <= 1'b0;
    tick(2);
    chk({30'h0, irq, wave}, 32'h0);
    hresetn <= 1'b1;
    tick(3);
    xfer(TCP_CTRL_OFS, 1'b0, 32'h0);
    chk(rd, 32'h880);
    final_report();
  end
endmodule
`default_nettype wire
